/* File: hfl_core.sv */
// Host FIFO level thresholds and receive data format control
`timescale 1ns/100ps
// Notes on behaviour
// - The byte order word reads as a fixed constant and cannot be written.
// - TX space interrupt sets when free space exceeds the threshold in 64-byte blocks.
// - TX status interrupt sets when TX status occupancy exceeds its threshold.
// - RX status interrupt sets when RX status occupancy exceeds its threshold.
// - The end of each receive buffer is padded with dwords to the chosen boundary.
// - End alignment codes 00, 01, 10 select 4, 16, 32 bytes; 11 is reserved.
// - The RX transfer interrupt rises once the counted dwords have been read.
// - The countdown drops per dword read and a new write replaces it.
// - Writing one to the purge bit clears RX data and status pointers, then clears itself.
// - The start offset field puts 0 to 31 bytes before each packet's data.
// - The upper offset bits may change live and apply from the next packet start or purge.
// - The level interrupt flags are sticky and cleared by writing one.
module hfl_core
  import hfl_pkg::*;
#(
  parameter int SPACE_W = 12, // TX free space in dwords
  parameter int LEVEL_W = 8
)(
  input  wire logic               ref_clk,
  input  wire logic               rst_b,
  input  wire hfl_req_s           req,
  input  wire logic               irq_clr_wr,
  input  wire hfl_irq_s           irq_clr,
  input  wire logic [SPACE_W-1:0] tx_free_dwords,
  input  wire logic [LEVEL_W-1:0] tx_stat_used,
  input  wire logic [LEVEL_W-1:0] rx_stat_used,
  input  wire logic               rx_dword_read,
  input  wire logic               rx_packet_start,
  input  wire logic               rx_buffer_last,
  output logic [31:0]             rdata,
  output logic                    rvalid,
  output hfl_irq_s                irq_flags,
  output logic                    rx_purge,
  output logic [4:0]              rx_start_offset,
  output logic [1:0]              end_align,
  output logic [2:0]              pad_dwords
);
  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  logic [7:0]  tx_space_thr;
  logic [7:0]  tx_stat_thr;
  logic [7:0]  rx_stat_thr;
  logic [11:0] rx_transfer_countdown;
  logic        count_armed;
  logic [4:0]  words_so_far;
  logic        wr_levels;
  logic        wr_rx_cfg;
  logic        space_hit;
  logic        tx_stat_hit;
  logic        rx_stat_hit;
  logic        dma_hit;

  function automatic logic over(input logic [SPACE_W-1:0] a, input logic [SPACE_W-1:0] b);
    over = a > b;
  endfunction

  assign wr_levels = req.wr && (req.addr == ADDR_LEVELS);
  assign wr_rx_cfg = req.wr && (req.addr == ADDR_RX_CFG);

  // Threshold register
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      tx_space_thr <= TX_SPACE_RST;
      tx_stat_thr  <= TX_STAT_RST;
      rx_stat_thr  <= RX_STAT_RST;
    end else if (wr_levels) begin
      tx_space_thr <= req.wdata[TX_SPACE_LSB +: 8];
      tx_stat_thr  <= req.wdata[TX_STAT_LSB +: 8];
      rx_stat_thr  <= req.wdata[RX_STAT_LSB +: 8];
    end
  end

  // Receive configuration fields, reserved bits dropped
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      end_align       <= END_ALIGN_RST;
      rx_start_offset <= START_OFF_RST;
    end else if (wr_rx_cfg) begin
      if (req.wdata[END_ALIGN_LSB +: 2] != HFL_ALIGN_RS) begin
        end_align <= req.wdata[END_ALIGN_LSB +: 2];
      end
      rx_start_offset <= req.wdata[START_OFF_LSB +: 5];
    end
  end

  // Self-clearing purge pulse
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rx_purge <= 1'b0;
    end else begin
      rx_purge <= wr_rx_cfg && req.wdata[PURGE_BIT];
    end
  end

  // Transfer countdown
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rx_transfer_countdown <= COUNTDOWN_RST;
      count_armed           <= 1'b0;
    end else if (wr_rx_cfg) begin
      rx_transfer_countdown <= req.wdata[COUNTDOWN_LSB +: 12];
      count_armed           <= req.wdata[COUNTDOWN_LSB +: 12] != COUNTDOWN_RST;
    end else if (rx_dword_read && count_armed) begin
      rx_transfer_countdown <= rx_transfer_countdown - 12'h001;
      if (rx_transfer_countdown == 12'h001) begin
        count_armed <= 1'b0;
      end
    end
  end

  assign dma_hit = count_armed && rx_dword_read && !wr_rx_cfg &&
                   (rx_transfer_countdown == 12'h001);

  // Dwords into current buffer for end padding
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      words_so_far <= 5'h00;
    end else if (rx_packet_start || rx_purge) begin
      words_so_far <= {2'h0, rx_start_offset[4:2]};
    end else if (rx_dword_read) begin
      words_so_far <= words_so_far + 5'h01;
    end
  end

  hfl_pad_calc u_pad (
    .ref_clk      (ref_clk),
    .rst_b        (rst_b),
    .align        (end_align),
    .words_so_far (words_so_far),
    .pad_dwords   (pad_dwords)
  );

  // ------------------------------------------------------------
  // Level compare and sticky flags
  // ------------------------------------------------------------
  assign space_hit   = over(tx_free_dwords,
                            SPACE_W'(tx_space_thr) << BLOCK_SHIFT);
  assign tx_stat_hit = tx_stat_used > tx_stat_thr;
  assign rx_stat_hit = rx_stat_used > rx_stat_thr;

  // Set wins over clear
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irq_flags <= '0;
    end else begin
      irq_flags.tx_space_avail_irq <= space_hit ||
        (irq_flags.tx_space_avail_irq && !(irq_clr_wr && irq_clr.tx_space_avail_irq));
      irq_flags.tx_stat_level_irq <= tx_stat_hit ||
        (irq_flags.tx_stat_level_irq && !(irq_clr_wr && irq_clr.tx_stat_level_irq));
      irq_flags.rx_stat_level_irq <= rx_stat_hit ||
        (irq_flags.rx_stat_level_irq && !(irq_clr_wr && irq_clr.rx_stat_level_irq));
      irq_flags.rx_dma <= dma_hit ||
        (irq_flags.rx_dma && !(irq_clr_wr && irq_clr.rx_dma));
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rdata  <= 32'h0;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      case (req.addr)
        ADDR_BYTE_ORDER: rdata <= BYTE_ORDER_WORD;
        ADDR_LEVELS:     rdata <= {tx_space_thr, tx_stat_thr, 8'h0, rx_stat_thr};
        ADDR_RX_CFG:     rdata <= {end_align, 2'h0, rx_transfer_countdown, 3'h0,
                                   rx_start_offset, 8'h0};
        default:         rdata <= 32'h0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  byte_order_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $past(req.rd) && $past(req.addr) == ADDR_BYTE_ORDER |-> rdata == BYTE_ORDER_WORD)
    else $error("byte order word wrong");
  tx_space_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    space_hit |=> irq_flags.tx_space_avail_irq)
    else $error("tx space flag missed");
  tx_stat_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tx_stat_used > tx_stat_thr |=> irq_flags.tx_stat_level_irq)
    else $error("tx status flag missed");
  rx_stat_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rx_stat_used > rx_stat_thr |=> irq_flags.rx_stat_level_irq)
    else $error("rx status flag missed");
  countdown_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rx_dword_read && count_armed && !wr_rx_cfg |=>
      rx_transfer_countdown == $past(rx_transfer_countdown) - 12'h001)
    else $error("countdown step wrong");
  purge_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_rx_cfg && req.wdata[PURGE_BIT] |=> rx_purge ##1
      (!rx_purge || $past(wr_rx_cfg && req.wdata[PURGE_BIT])))
    else $error("purge not self clearing");
  align_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_rx_cfg && req.wdata[END_ALIGN_LSB +: 2] == HFL_ALIGN_RS |=>
      end_align == $past(end_align))
    else $error("reserved alignment taken");
  offset_load_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_rx_cfg |=> rx_start_offset == $past(req.wdata[START_OFF_LSB +: 5]))
    else $error("start offset not loaded");
  reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $past(req.rd) && $past(req.addr) == ADDR_RX_CFG |->
      rdata[29:28] == 2'h0 && rdata[15:13] == 3'h0 && rdata[7:0] == 8'h0)
    else $error("reserved bits not zero");
  dma_irq_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    dma_hit |=> irq_flags.rx_dma && rx_transfer_countdown == 12'h000)
    else $error("dma interrupt missed");
  clear_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    irq_clr_wr && irq_clr.tx_stat_level_irq && !tx_stat_hit |=>
      !irq_flags.tx_stat_level_irq)
    else $error("flag not cleared");
endmodule

/* File: hfl_pkg.sv */
// Package for host FIFO level and receive format block
package hfl_pkg;
  localparam logic [7:0]  ADDR_BYTE_ORDER = 8'h64;
  localparam logic [7:0]  ADDR_LEVELS     = 8'h68;
  localparam logic [7:0]  ADDR_RX_CFG     = 8'h6c;
  localparam logic [31:0] BYTE_ORDER_WORD = 32'h87654321;
  localparam logic [7:0]  TX_SPACE_RST    = 8'h48;
  localparam logic [7:0]  TX_STAT_RST     = 8'h00;
  localparam logic [7:0]  RX_STAT_RST     = 8'h00;
  localparam logic [1:0]  END_ALIGN_RST   = 2'h0;
  localparam logic [11:0] COUNTDOWN_RST   = 12'h000;
  localparam logic [4:0]  START_OFF_RST   = 5'h00;
  localparam logic [2:0]  IRQ_BIT_TX_SPACE = 3'h0;
  localparam logic [2:0]  IRQ_BIT_TX_STAT  = 3'h1;
  localparam logic [2:0]  IRQ_BIT_RX_STAT  = 3'h2;
  localparam logic [2:0]  IRQ_BIT_RX_DMA   = 3'h3;
  localparam int          BLOCK_SHIFT     = 4; // 64 bytes = 16 dwords
  localparam int          PURGE_BIT       = 15;
  localparam int          TX_SPACE_LSB    = 24;
  localparam int          TX_STAT_LSB     = 16;
  localparam int          RX_STAT_LSB     = 0;
  localparam int          END_ALIGN_LSB   = 30;
  localparam int          COUNTDOWN_LSB   = 16;
  localparam int          START_OFF_LSB   = 8;

  typedef enum logic [1:0] {
    HFL_ALIGN_4  = 2'b00,
    HFL_ALIGN_16 = 2'b01,
    HFL_ALIGN_32 = 2'b10,
    HFL_ALIGN_RS = 2'b11
  } hfl_align_e;

  // Host bus request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } hfl_req_s;

  // Interrupt flags, sticky, write one to clear
  typedef struct packed {
    logic rx_dma;
    logic rx_stat_level_irq;
    logic tx_stat_level_irq;
    logic tx_space_avail_irq;
  } hfl_irq_s;
endpackage

/* File: hfl_pad_calc.sv */
// Padding dword count for receive end alignment
`timescale 1ns/100ps
module hfl_pad_calc
  import hfl_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic [1:0] align,
  input  wire logic [4:0] words_so_far,
  output logic      [2:0] pad_dwords
);
  logic [2:0] mask;

  // Dwords per alignment boundary minus one
  always_comb begin
    case (hfl_align_e'(align))
      HFL_ALIGN_16: mask = 3'h3;
      HFL_ALIGN_32: mask = 3'h7;
      default:      mask = 3'h0;
    endcase
  end

  // Registered pad count to next boundary
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pad_dwords <= 3'h0;
    end else begin
      pad_dwords <= (3'h0 - words_so_far[2:0]) & mask;
    end
  end
endmodule

/* File: hfl_host_model.sv */
// Host processor model issuing register reads and writes
`timescale 1ns/100ps
module hfl_host_model
  import hfl_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic [31:0] rdata,
  output hfl_req_s         req
);
  // Bus idle from time zero
  initial req = '0;
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  // Write strobe for one cycle; alignment and low offset bits change only between packets
  task automatic write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk) req <= '{1'b0, 1'b1, a, d};
    @(posedge ref_clk) req <= '0;
  endtask
  // Read strobe, data taken one cycle later
  task automatic read(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk) req <= '{1'b1, 1'b0, a, 32'h0};
    @(posedge ref_clk) req <= '0;
    #1 d = rdata;
  endtask
endmodule

/* File: tb_host_fifo_level_and_rx_format.sv */
// Self-checking bench for the host FIFO level and receive format core
`timescale 1ns/100ps
module tb_host_fifo_level_and_rx_format;
  import hfl_pkg::*;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] exp;
  } hfl_row_s;
  logic        ref_clk, rst_b, irq_clr_wr, rx_dword_read, rx_packet_start, rvalid, rx_purge;
  logic [11:0] tx_free_dwords;
  logic [7:0]  tx_stat_used, rx_stat_used;
  logic [31:0] rdata, rd_val;
  logic [4:0]  rx_start_offset;
  logic [1:0]  end_align;
  logic [2:0]  pad_dwords;
  hfl_req_s    req;
  hfl_irq_s    irq_clr, irq_flags;
  int          err_count, checks, cycles;
  hfl_row_s    rows [8] = '{
    '{1'b0, 8'h64, 32'h0, 32'h87654321}, '{1'b0, 8'h68, 32'h0, 32'h48000000},
    '{1'b0, 8'h6c, 32'h0, 32'h00000000}, '{1'b1, 8'h64, 32'hffffffff, 32'h87654321},
    '{1'b1, 8'h68, 32'hffffffff, 32'hffff00ff}, '{1'b1, 8'h6c, 32'hffff7fff, 32'h0fff1f00},
    '{1'b1, 8'h6c, 32'h80000000, 32'h80000000}, '{1'b0, 8'h70, 32'h0, 32'h00000000}};
  hfl_host_model host (.ref_clk(ref_clk), .rdata(rdata), .req(req));
  hfl_core DUT (.ref_clk(ref_clk), .rst_b(rst_b), .req(req), .irq_clr_wr(irq_clr_wr),
    .irq_clr(irq_clr), .tx_free_dwords(tx_free_dwords), .tx_stat_used(tx_stat_used),
    .rx_stat_used(rx_stat_used), .rx_dword_read(rx_dword_read),
    .rx_packet_start(rx_packet_start), .rx_buffer_last(1'b0), .rdata(rdata), .rvalid(rvalid),
    .irq_flags(irq_flags), .rx_purge(rx_purge), .rx_start_offset(rx_start_offset),
    .end_align(end_align), .pad_dwords(pad_dwords));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic pulse_reads(input int n);
    repeat (n) begin
      @(posedge ref_clk) rx_dword_read <= 1'b1;
      @(posedge ref_clk) rx_dword_read <= 1'b0;
    end
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  // Clock generator
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_b, irq_clr_wr, rx_dword_read, rx_packet_start} = '0;
    {irq_clr, tx_free_dwords, tx_stat_used, rx_stat_used} = '0;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    // Table of register accesses
    foreach (rows[i]) begin
      if (rows[i].wr) host.write(rows[i].addr, rows[i].wdata);
      host.read(rows[i].addr, rd_val);
      check(rd_val, rows[i].exp);
      check({31'h0, rvalid}, 32'h1);
    end
    // Level thresholds at and above the boundary
    host.write(ADDR_LEVELS, 32'h02050003);
    tx_free_dwords <= 12'd32;
    tx_stat_used <= 8'd5;
    rx_stat_used <= 8'd3;
    settle();
    check({29'h0, irq_flags[2:0]}, 32'h0);
    @(posedge ref_clk);
    tx_free_dwords <= 12'd33;
    tx_stat_used <= 8'd6;
    rx_stat_used <= 8'd4;
    settle();
    check({29'h0, irq_flags[2:0]}, 32'h7);
    @(posedge ref_clk);
    {tx_free_dwords, tx_stat_used, rx_stat_used} <= '0;
    settle();
    check({29'h0, irq_flags[2:0]}, 32'h7);
    @(posedge ref_clk);
    irq_clr <= 4'h7;
    irq_clr_wr <= 1'b1;
    @(posedge ref_clk) irq_clr_wr <= 1'b0;
    settle();
    check({29'h0, irq_flags[2:0]}, 32'h0);
    // Countdown with replacement before zero
    host.write(ADDR_RX_CFG, 32'h00030000);
    pulse_reads(2);
    host.write(ADDR_RX_CFG, 32'h00030000);
    pulse_reads(1);
    check({31'h0, irq_flags.rx_dma}, 32'h0);
    pulse_reads(2);
    check({31'h0, irq_flags.rx_dma}, 32'h1);
    // Purge pulses once and self-clears
    host.write(ADDR_RX_CFG, 32'h00008000);
    #1 check({31'h0, rx_purge}, 32'h1);
    @(posedge ref_clk) #1 check({31'h0, rx_purge}, 32'h0);
    check({31'h0, rvalid}, 32'h0);
    // Dword offset 2, 16-byte end alignment, one word read
    host.write(ADDR_RX_CFG, 32'h40000800);
    @(posedge ref_clk) rx_packet_start <= 1'b1;
    @(posedge ref_clk) rx_packet_start <= 1'b0;
    pulse_reads(1);
    check({27'h0, rx_start_offset}, 32'h8);
    check({29'h0, pad_dwords}, 32'h1);
    // 32-byte end alignment, no offset, three words read
    host.write(ADDR_RX_CFG, 32'h80000000);
    @(posedge ref_clk) rx_packet_start <= 1'b1;
    @(posedge ref_clk) rx_packet_start <= 1'b0;
    pulse_reads(3);
    check({30'h0, end_align}, 32'h2);
    check({29'h0, pad_dwords}, 32'h5);
    // Reset in mid-run brings every field back to its default
    @(posedge ref_clk) rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    host.read(ADDR_LEVELS, rd_val);
    check(rd_val, 32'h48000000);
    host.read(ADDR_RX_CFG, rd_val);
    check(rd_val, 32'h00000000);
    check({28'h0, irq_flags}, 32'h0);
    check({29'h0, pad_dwords}, 32'h0);
    give_verdict();
  end
endmodule
